// file: rtl/spk_regs.vh
/*
  Constants for the speakerphone duplex, AGC and suppression block: register
  indices, field positions, reset values and sample-rate timing.
  Assumes one codec sample strobe at the nominal rate below.
*/
`ifndef SPK_REGS_VH
`define SPK_REGS_VH

// Register indices; byte address is four times the index.
`define SPK_IDX_W0      3'd0
`define SPK_IDX_W1      3'd1
`define SPK_IDX_W2      3'd2
`define SPK_IDX_W3      3'd3
`define SPK_IDX_STAT    3'd4
`define SPK_IDX_CTRL    3'd5

`define SPK_RST_W0      16'h0a10
`define SPK_RST_W1      16'h0a00
`define SPK_RST_W2      16'h0000
`define SPK_RST_W3      16'h0060
`define SPK_RST_CTRL    5'h00

// Word 0 and word 1 fields.
`define SPK_VOL_HI      11
`define SPK_VOL_LO      8
`define SPK_TSMODE      4
`define SPK_DET_HI      15
`define SPK_DET_LO      14
// Word 2 fields.
`define SPK_RX_SUPP_SPEECH_THRESHOLD_HI    13
`define SPK_RX_SUPP_SPEECH_THRESHOLD_LO    12
`define SPK_RAMP_HI     11
`define SPK_RAMP_LO     10
`define SPK_HOLD_HI     9
`define SPK_HOLD_LO     8
// Word 3 fields.
`define SPK_TSLOSS_HI   15
`define SPK_TSLOSS_LO   14
`define SPK_TX_SUPP_ERLE_THRESHOLD_HI    7
`define SPK_TX_SUPP_ERLE_THRESHOLD_LO    6
`define SPK_TX_SUPP_RELEASE_BIAS_HI   5
`define SPK_TX_SUPP_RELEASE_BIAS_LO   4
// Control register fields.
`define SPK_DTTX_HI     1
`define SPK_DTTX_LO     0
`define SPK_DTRX_HI     3
`define SPK_DTRX_LO     2
`define SPK_IDLERET     4

// Half-duplex states.
`define SPK_ST_IDLE     2'd0
`define SPK_ST_TX       2'd1
`define SPK_ST_RX       2'd2

// Thresholds in 3 dB units: detector 6 dB + 3 dB per code, ERLE/bias 12 dB + 3 dB per code.
`define SPK_DET_BASE    3'd2
`define SPK_ERLE_BASE   3'd4
`define SPK_TXSUP_DET   3'd2
// Losses as right shifts of 6 dB each.
`define SPK_RXSUP_SH    4'd4
`define SPK_LOSS_MAX    5'd15

// Sample-rate timing.
`define SPK_FS_HZ       8000
`define SPK_ATTACK_US   125
`define SPK_DECAY_MS    30
`define SPK_ATTACK_SMP  ((`SPK_ATTACK_US * `SPK_FS_HZ + 999999) / 1000000)
`define SPK_DECAY_SH    8
`define SPK_HOLD_S0     12'd400
`define SPK_HOLD_S1     12'd800
`define SPK_HOLD_S2     12'd1600
`define SPK_HOLD_S3     12'd3200
`define SPK_RAMP_S0     10'd64
`define SPK_RAMP_S1     10'd128
`define SPK_RAMP_S2     10'd256
`define SPK_RAMP_S3     10'd512
`define SPK_ADAPT_SMP   14'd8000
`define SPK_PWR_SH      5
`define SPK_NF_MIN      16'h0010

// Gain arithmetic.
`define SPK_VOL_ZERO    5'sd10
`define SPK_VOL_MUTE    4'hf
`define SPK_MANT_0DB    15'h4000
`define SPK_MANT_3DB    15'h5a82
`define SPK_ATT_ONE     16'h7fff
`define SPK_FS_POS      25'sh0007fff
`define SPK_FS_NEG      -25'sh0008000

`define SPK_RESP_OK     2'b00
`define SPK_RESP_ERR    2'b10

`endif

// file: rtl/spk_gain_path.v
/*
  One direction of the voice path: peak-limiting AGC with post-scaling volume,
  then extra suppression loss and mute. Output is registered per sample.
  Assumes smp_en is a one-cycle sample strobe and the loss/mute inputs are stable.
*/
`timescale 1ns/100ps
`include "spk_regs.vh"
module spk_gain_path (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        smp_en,
  input  wire [15:0] smp_in,
  input  wire [3:0]  vol_code,
  input  wire [3:0]  loss_sh,
  input  wire        mute,
  output reg  [15:0] smp_out
);

reg  [15:0]        att_q;
reg  [15:0]        att_d;
wire signed [4:0]  g3 = `SPK_VOL_ZERO - $signed({1'b0, vol_code});
wire [14:0]        mant = g3[0] ? `SPK_MANT_3DB : `SPK_MANT_0DB;
wire signed [4:0]  ex = g3 >>> 1;
wire [2:0]         e_up = ex[4] ? 3'd0 : ex[2:0];
wire [2:0]         e_dn = ex[4] ? 3'd0 - ex[2:0] : 3'd0;
wire signed [32:0] p1 = $signed(smp_in) * $signed({1'b0, att_q});
wire signed [16:0] p1s = p1[31:15];
wire signed [32:0] p2 = p1s * $signed({1'b0, mant});
wire signed [18:0] p2s = p2[32:14];
wire signed [24:0] p3 = ($signed({{6{p2s[18]}}, p2s}) <<< e_up) >>> e_dn;
wire               over_hi = p3 > `SPK_FS_POS;
wire               over_lo = p3 < `SPK_FS_NEG;
wire signed [15:0] sat = over_hi ? 16'sh7fff : (over_lo ? 16'sh8000 : p3[15:0]);

// Attack halves the gain each sample, fast enough to settle within the attack time.
always @*
begin
  if (over_hi || over_lo)
    att_d = att_q - (att_q >> `SPK_ATTACK_SMP);
  else
    att_d = att_q + ((`SPK_ATT_ONE - att_q) >> `SPK_DECAY_SH);
end

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    att_q   <= `SPK_ATT_ONE;
    smp_out <= 16'h0000;
  end
  else if (smp_en)
  begin
    att_q <= att_d;
    if (mute || vol_code == `SPK_VOL_MUTE)
      smp_out <= 16'h0000;
    else
      smp_out <= sat >>> loss_sh;
  end
end

endmodule // spk_gain_path

// file: rtl/spk_duplex_ctrl.v
/*
  Speakerphone voice-path control: half-duplex switch, speech detectors,
  AGC/volume per direction, echo suppression, double-talk loss, AXI4-Lite registers.
  Assumes tx_in/rx_in are samples taken between the two echo cancellers and
  that the cancellers report adequate ERLE on aec_ok/nec_ok.
*/
`timescale 1ns/100ps
`include "spk_regs.vh"
// Notes on behaviour
// - Reset clears canceller coefficients and starts in half-duplex mode.
// - Half-duplex ends by itself once cancellers have adapted long enough.
// - Half-duplex has transmit, receive and idle states with path mutes.
// - Transmit and receive only change through idle.
// - Holdover keeps the state after speech stops, chosen by word 2 bits 9:8.
// - With idle-return on, idle goes back to transmit in half-duplex.
// - AGC in each direction uses word 1 or word 0 bits 11:8 as reference.
// - Levels above reference are cut to it with a 125 us attack.
// - AGC attenuation decays with 30 ms time constant unless renewed.
// - Post-scaler lifts the reference level to full scale.
// - Volume codes step 3 dB from +30 dB down to -12 dB.
// - Volume code 1111 mutes the path.
// - Volume scaling sits between the two cancellers.
// - Transmit suppression loss comes from word 3 bits 15:14.
// - Receive suppression attenuates by 24 dB.
// - Word 0 bit 4 picks far-end-only or noise-guard transmit suppression.
// - Word 3 bits 7:6 set the ERLE expectation, default 15 dB.
// - Word 3 bits 5:4 set release bias, default 18 dB.
// - Near-end speech removes transmit suppression loss.
// - Receive suppression attenuates unless far-end speech is detected.
// - Receive suppression detector threshold comes from word 2 bits 13:12.
// - Double-talk can add programmable loss to either path.
// - Speech is power above tracked noise by threshold; noise rises slow, falls fast.
// - Receive and transmit half-duplex thresholds from word 2 and word 1 bits 15:14.
// - Noise estimate steps up 3 dB at intervals set by word 2 bits 11:10.
module spk_duplex_ctrl (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        smp_en,
  input  wire [15:0] tx_in,
  input  wire [15:0] rx_in,
  input  wire        aec_ok,
  input  wire        nec_ok,
  output wire [15:0] tx_out,
  output wire [15:0] rx_out,
  output reg         out_valid,
  output reg         ec_coef_clear
);

////////////////////////////////////////////////////////////////////////////////
// Register file.

reg  [15:0] w0_q;
reg  [15:0] w1_q;
reg  [15:0] w2_q;
reg  [15:0] w3_q;
reg  [4:0]  ctrl_q;
reg  [8:0]  stat;
wire        wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire        rd_go = s_axi_arvalid && !s_axi_rvalid;
wire [2:0]  wr_idx = s_axi_awaddr[4:2];
wire [2:0]  rd_idx = s_axi_araddr[4:2];
wire        wr_map = s_axi_awaddr[7:5] == 3'd0 && wr_idx <= `SPK_IDX_CTRL;
wire        rd_map = s_axi_araddr[7:5] == 3'd0 && rd_idx <= `SPK_IDX_CTRL;

assign s_axi_awready = wr_go;
assign s_axi_wready  = wr_go;
assign s_axi_arready = !s_axi_rvalid;

function [15:0] merge;
  input [15:0] old;
  input [31:0] dat;
  input [3:0]  stb;
  begin
    merge = {stb[1] ? dat[15:8] : old[15:8], stb[0] ? dat[7:0] : old[7:0]};
  end
endfunction

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    w0_q         <= `SPK_RST_W0;
    w1_q         <= `SPK_RST_W1;
    w2_q         <= `SPK_RST_W2;
    w3_q         <= `SPK_RST_W3;
    ctrl_q       <= `SPK_RST_CTRL;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= `SPK_RESP_OK;
  end
  else
  begin
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
    if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `SPK_RESP_OK : `SPK_RESP_ERR;
      case (wr_idx)
        `SPK_IDX_W0: w0_q <= merge(w0_q, s_axi_wdata, s_axi_wstrb);
        `SPK_IDX_W1: w1_q <= merge(w1_q, s_axi_wdata, s_axi_wstrb);
        `SPK_IDX_W2: w2_q <= merge(w2_q, s_axi_wdata, s_axi_wstrb);
        `SPK_IDX_W3: w3_q <= merge(w3_q, s_axi_wdata, s_axi_wstrb);
        `SPK_IDX_CTRL:
          if (s_axi_wstrb[0])
            ctrl_q <= s_axi_wdata[4:0];
        default: ;
      endcase
    end
  end
end

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h0000_0000;
    s_axi_rresp  <= `SPK_RESP_OK;
  end
  else if (rd_go)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp  <= rd_map ? `SPK_RESP_OK : `SPK_RESP_ERR;
    case (rd_idx)
      `SPK_IDX_W0:   s_axi_rdata <= {16'h0000, w0_q};
      `SPK_IDX_W1:   s_axi_rdata <= {16'h0000, w1_q};
      `SPK_IDX_W2:   s_axi_rdata <= {16'h0000, w2_q};
      `SPK_IDX_W3:   s_axi_rdata <= {16'h0000, w3_q};
      `SPK_IDX_STAT: s_axi_rdata <= {23'h000000, stat};
      `SPK_IDX_CTRL: s_axi_rdata <= {27'h0000000, ctrl_q};
      default:       s_axi_rdata <= 32'h0000_0000;
    endcase
  end
  else if (s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Power estimators and noise floors.

// Scales an amplitude estimate by a whole number of 3 dB steps.
function [23:0] up3;
  input [15:0] x;
  input [2:0]  u;
  reg   [23:0] b;
  begin
    b   = {8'h00, x} << u[2:1];
    up3 = u[0] ? b + (b >> 2) + (b >> 3) + (b >> 5) : b;
  end
endfunction

reg  [15:0] tx_pw_q;
reg  [15:0] rx_pw_q;
reg  [15:0] tx_nf_q;
reg  [15:0] rx_nf_q;
reg  [9:0]  ramp_q;
reg  [9:0]  ramp_len;
wire [15:0] tx_abs = tx_in[15] ? 16'h0000 - tx_in : tx_in;
wire [15:0] rx_abs = rx_in[15] ? 16'h0000 - rx_in : rx_in;
wire        ramp_hit = ramp_q >= ramp_len;

always @*
begin
  case (w2_q[`SPK_RAMP_HI:`SPK_RAMP_LO])
    2'd0:    ramp_len = `SPK_RAMP_S0;
    2'd1:    ramp_len = `SPK_RAMP_S1;
    2'd2:    ramp_len = `SPK_RAMP_S2;
    default: ramp_len = `SPK_RAMP_S3;
  endcase
end

// Raises a floor one step toward the power, drops it at once to the power when above it.
function [15:0] nf_next;
  input [15:0] nf;
  input [15:0] pw;
  input        hit;
  reg   [23:0] s;
  begin
    s = up3(nf, 3'd1);
    if (pw < nf)
      nf_next = pw < `SPK_NF_MIN ? `SPK_NF_MIN : pw;
    else if (hit)
      nf_next = s > {8'h00, pw} ? pw : s[15:0];
    else
      nf_next = nf;
  end
endfunction

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    tx_pw_q <= 16'h0000;
    rx_pw_q <= 16'h0000;
    tx_nf_q <= `SPK_NF_MIN;
    rx_nf_q <= `SPK_NF_MIN;
    ramp_q  <= 10'd0;
  end
  else if (smp_en)
  begin
    tx_pw_q <= tx_pw_q - (tx_pw_q >> `SPK_PWR_SH) + (tx_abs >> `SPK_PWR_SH);
    rx_pw_q <= rx_pw_q - (rx_pw_q >> `SPK_PWR_SH) + (rx_abs >> `SPK_PWR_SH);
    tx_nf_q <= nf_next(tx_nf_q, tx_pw_q, ramp_hit);
    rx_nf_q <= nf_next(rx_nf_q, rx_pw_q, ramp_hit);
    ramp_q  <= ramp_hit ? 10'd0 : ramp_q + 10'd1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Speech detectors and suppression decisions.

wire [2:0] thd_tx = `SPK_DET_BASE + {1'b0, w1_q[`SPK_DET_HI:`SPK_DET_LO]};
wire [2:0] thd_rx = `SPK_DET_BASE + {1'b0, w2_q[`SPK_DET_HI:`SPK_DET_LO]};
wire [2:0] thd_rs = `SPK_DET_BASE + {1'b0, w2_q[`SPK_RX_SUPP_SPEECH_THRESHOLD_HI:`SPK_RX_SUPP_SPEECH_THRESHOLD_LO]};
wire [2:0] erle_u = `SPK_ERLE_BASE + {1'b0, w3_q[`SPK_TX_SUPP_ERLE_THRESHOLD_HI:`SPK_TX_SUPP_ERLE_THRESHOLD_LO]};
wire [2:0] bias_u = `SPK_ERLE_BASE + {1'b0, w3_q[`SPK_TX_SUPP_RELEASE_BIAS_HI:`SPK_TX_SUPP_RELEASE_BIAS_LO]};
wire       tx_hd_sp = {8'h00, tx_pw_q} > up3(tx_nf_q, thd_tx);
wire       rx_hd_sp = {8'h00, rx_pw_q} > up3(rx_nf_q, thd_rx);
wire       fes = {8'h00, rx_pw_q} > up3(rx_nf_q, thd_rs);
wire       tx_sp = {8'h00, tx_pw_q} > up3(tx_nf_q, `SPK_TXSUP_DET);
// Near-end talk must beat the expected echo; once declared, the bias keeps it.
wire       nes_on = up3(tx_pw_q, erle_u) > {8'h00, rx_pw_q};
wire       nes_keep = up3(tx_pw_q, bias_u) > {8'h00, rx_pw_q};
reg        nes_q;
wire       ts_eng = w0_q[`SPK_TSMODE] ? fes && !nes_q : !nes_q;
wire       rs_eng = !fes;
wire       dbl = nes_q && fes;

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
    nes_q <= 1'b0;
  else if (smp_en)
    nes_q <= tx_sp && (nes_q ? nes_keep : nes_on);
end

////////////////////////////////////////////////////////////////////////////////
// Half-duplex switch and adaptation watch.

reg  [1:0]  st_q;
reg  [1:0]  st_d;
reg  [11:0] hold_q;
reg  [11:0] hold_len;
reg  [13:0] adapt_q;
reg         hd_q;
wire        cur_sp = st_q == `SPK_ST_TX ? tx_hd_sp : rx_hd_sp;

always @*
begin
  case (w2_q[`SPK_HOLD_HI:`SPK_HOLD_LO])
    2'd0:    hold_len = `SPK_HOLD_S0;
    2'd1:    hold_len = `SPK_HOLD_S1;
    2'd2:    hold_len = `SPK_HOLD_S2;
    default: hold_len = `SPK_HOLD_S3;
  endcase
end

// Receive wins a tie from idle, so the far end is never cut off by echo.
always @*
begin
  case (st_q)
    `SPK_ST_IDLE:
      if (rx_hd_sp)
        st_d = `SPK_ST_RX;
      else if (tx_hd_sp || ctrl_q[`SPK_IDLERET])
        st_d = `SPK_ST_TX;
      else
        st_d = `SPK_ST_IDLE;
    `SPK_ST_TX, `SPK_ST_RX:
      if (!cur_sp && hold_q == 12'd0)
        st_d = `SPK_ST_IDLE;
      else
        st_d = st_q;
    default: st_d = `SPK_ST_IDLE;
  endcase
end

always @(posedge clk_sys or negedge rstn)
begin
  if (!rstn)
  begin
    st_q          <= `SPK_ST_IDLE;
    hold_q        <= 12'd0;
    adapt_q       <= 14'd0;
    hd_q          <= 1'b1;
    ec_coef_clear <= 1'b1;
    out_valid     <= 1'b0;
  end
  else
  begin
    ec_coef_clear <= 1'b0;
    out_valid     <= smp_en;
    if (smp_en)
    begin
      st_q <= hd_q ? st_d : `SPK_ST_IDLE;
      if (st_d != st_q || cur_sp)
        hold_q <= hold_len;
      else if (hold_q != 12'd0)
        hold_q <= hold_q - 12'd1;
      // Adaptation must hold without a break before full duplex is trusted.
      if (!(aec_ok && nec_ok))
        adapt_q <= 14'd0;
      else if (adapt_q != `SPK_ADAPT_SMP)
        adapt_q <= adapt_q + 14'd1;
      if (adapt_q == `SPK_ADAPT_SMP)
        hd_q <= 1'b0;
    end
  end
end

always @*
begin
  stat = {rs_eng, ts_eng, fes, nes_q, rx_hd_sp, tx_hd_sp, st_q, hd_q};
end

////////////////////////////////////////////////////////////////////////////////
// Gain paths, placed between the cancellers so volume never alters the echo path.

wire [4:0] tx_loss = (ts_eng ? {3'd0, w3_q[`SPK_TSLOSS_HI:`SPK_TSLOSS_LO]} + 5'd1 : 5'd0)
                     + (dbl ? {3'd0, ctrl_q[`SPK_DTTX_HI:`SPK_DTTX_LO]} : 5'd0);
wire [4:0] rx_loss = (rs_eng ? {1'b0, `SPK_RXSUP_SH} : 5'd0)
                     + (dbl ? {3'd0, ctrl_q[`SPK_DTRX_HI:`SPK_DTRX_LO]} : 5'd0);
wire       tx_mute = hd_q && st_q == `SPK_ST_RX;
wire       rx_mute = hd_q && st_q == `SPK_ST_TX;

spk_gain_path u_tx (
  .clk_sys  (clk_sys),
  .rstn     (rstn),
  .smp_en   (smp_en),
  .smp_in   (tx_in),
  .vol_code (w1_q[`SPK_VOL_HI:`SPK_VOL_LO]),
  .loss_sh  (tx_loss > `SPK_LOSS_MAX ? 4'hf : tx_loss[3:0]),
  .mute     (tx_mute),
  .smp_out  (tx_out)
);

spk_gain_path u_rx (
  .clk_sys  (clk_sys),
  .rstn     (rstn),
  .smp_en   (smp_en),
  .smp_in   (rx_in),
  .vol_code (w0_q[`SPK_VOL_HI:`SPK_VOL_LO]),
  .loss_sh  (rx_loss > `SPK_LOSS_MAX ? 4'hf : rx_loss[3:0]),
  .mute     (rx_mute),
  .smp_out  (rx_out)
);

endmodule // spk_duplex_ctrl

// file: sim/spk_duplex_ctrl_properties.sv
/*
  Port-level assertions for the duplex control block.
  Assumes one clock domain and the asynchronous active-low reset rstn.
*/
`timescale 1ns/100ps
module spk_duplex_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        smp_en,
  input wire logic [15:0] tx_out,
  input wire logic [15:0] rx_out,
  input wire logic        out_valid,
  input wire logic        ec_coef_clear
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  sequence s_out_pulse;
    out_valid ##1 !out_valid;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rready ##1 !s_axi_rvalid;
  endsequence
  a_sample_pulse: assert property (smp_en |=> s_out_pulse)
    else $error("out_valid did not pulse after a sample strobe");
  a_valid_cause: assert property (out_valid |-> $past(smp_en))
    else $error("out_valid without a preceding sample strobe");
  a_out_hold: assert property (!out_valid |-> $stable(tx_out) && $stable(rx_out))
    else $error("sample outputs changed off a sample boundary");
  a_coef_clear_low: assert property ($past(rstn) |-> !ec_coef_clear)
    else $error("coefficient clear still high after reset release");
  a_wr_ready: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
                               && s_axi_wready == s_axi_awready)
    else $error("write ready does not follow both valids");
  a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing one cycle after acceptance");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing one cycle after acceptance");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |-> s_rd_done)
    else $error("read valid not released after handshake");
  a_ar_level: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready does not mirror a free read channel");
endmodule // spk_duplex_props

bind spk_duplex_ctrl spk_duplex_props u_props (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .smp_en, .tx_out, .rx_out, .out_valid, .ec_coef_clear);

// file: sim/spk_codec_model.sv
/*
  Codec and canceller stand-in: sample strobe, alternating-sign samples
  and the cancellers' adaptation flags.
  Assumes the bench sets amplitudes and the adaptation request.
*/
`timescale 1ns/100ps
module spk_codec_model #(
  parameter int PER = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] amp_tx,
  input  wire logic [15:0] amp_rx,
  input  wire logic        ok_req,
  output logic             smp_en,
  output logic [15:0]      tx_in,
  output logic [15:0]      rx_in,
  output logic             aec_ok,
  output logic             nec_ok
);
  logic [7:0] cnt_q;
  logic       ph_q;
  // Between strobes the sample lines toggle, so a design that samples off the strobe sees junk.
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      cnt_q <= 8'h00;
      ph_q <= 1'b0;
      smp_en <= 1'b0;
      tx_in <= 16'h0000;
      rx_in <= 16'h0000;
      aec_ok <= 1'b0;
      nec_ok <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
      smp_en <= (cnt_q == 8'(PER - 1));
      aec_ok <= ok_req;
      nec_ok <= ok_req;
      if (cnt_q == 8'(PER - 1))
      begin
        ph_q <= !ph_q;
        tx_in <= ph_q ? amp_tx : -amp_tx;
        rx_in <= ph_q ? amp_rx : -amp_rx;
      end
      else
      begin
        tx_in <= ~tx_in;
        rx_in <= ~rx_in;
      end
    end
endmodule // spk_codec_model

// file: sim/tb_top.sv
/*
  Self-checking bench for the duplex control block.
  Assumes the codec model supplies samples every four clocks.
*/
`timescale 1ns/100ps
`include "spk_regs.vh"
module tb_top;
  logic        clk_sys, rstn, smp_en, aec_ok, nec_ok, out_valid, ec_coef_clear, ok_req;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] tx_in, rx_in, tx_out, rx_out, amp_tx, amp_rx;
  int          failures, total_checks;
  spk_duplex_ctrl uut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .smp_en,
    .tx_in, .rx_in, .aec_ok, .nec_ok, .tx_out, .rx_out, .out_valid, .ec_coef_clear);
  spk_codec_model #(.PER(4)) u_codec (.clk_sys, .rstn, .amp_tx, .amp_rx, .ok_req, .smp_en, .tx_in, .rx_in,
    .aec_ok, .nec_ok);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic wait_smp(input int n);
    repeat (n)
    begin
      do @(posedge clk_sys); while (!out_valid);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [15:0] exp_w [4];
    exp_w = '{`SPK_RST_W0, `SPK_RST_W1, `SPK_RST_W2, `SPK_RST_W3};
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(8'(i * 4));
      check(rd, {16'h0000, exp_w[i]});
    end
    axi_rd(8'h14);
    check(rd, 32'h0000_0000);
    axi_rd(8'h10);
    check(rd[2:0], 3'b001);
    check(ec_coef_clear, 1'b0);
    axi_rd(8'h18);
    check(rs, `SPK_RESP_ERR);
    check(rd, 32'h0);
    axi_wr(8'h1c, 32'h0000_ffff, 4'hf, `SPK_RESP_ERR);
    axi_wr(8'h10, 32'h0000_0000, 4'hf, `SPK_RESP_OK);
    axi_rd(8'h10);
    check(rd[0], 1'b1);
  endtask
  task automatic t_regs;
    axi_wr(8'h08, 32'h0000_ff55, 4'h2, `SPK_RESP_OK);
    axi_rd(8'h08);
    check(rd, 32'h0000_ff00);
    axi_wr(8'h08, 32'h0, 4'h3, `SPK_RESP_OK);
    axi_wr(8'h14, 32'h0000_001f, 4'h1, `SPK_RESP_OK);
    axi_rd(8'h14);
    check(rd, 32'h0000_001f);
    axi_wr(8'h14, 32'h0, 4'h1, `SPK_RESP_OK);
  endtask
  task automatic t_mute;
    amp_tx <= 16'h2000;
    amp_rx <= 16'h2000;
    axi_wr(8'h00, 32'h0000_0f10, 4'h3, `SPK_RESP_OK);
    axi_wr(8'h04, 32'h0000_0f00, 4'h3, `SPK_RESP_OK);
    wait_smp(4);
    check({tx_out, rx_out}, 32'h0);
    axi_wr(8'h00, {16'h0, `SPK_RST_W0}, 4'h3, `SPK_RESP_OK);
    axi_wr(8'h04, {16'h0, `SPK_RST_W1}, 4'h3, `SPK_RESP_OK);
    amp_tx <= 16'h0000;
    amp_rx <= 16'h0000;
  endtask
  // Earlier traffic leaves a state under holdover, so idle must be reached before idle-return is tried.
  task automatic t_idle_ret;
    wait_smp(800);
    axi_rd(8'h10);
    check(rd[2:0], 3'b001);
    axi_wr(8'h14, 32'h0000_0010, 4'h1, `SPK_RESP_OK);
    wait_smp(8);
    axi_rd(8'h10);
    check(rd[2:0], 3'b011);
    axi_wr(8'h14, 32'h0, 4'h1, `SPK_RESP_OK);
  endtask
  // The adaptation count is in samples, so the run is long; margins absorb strobe phase.
  task automatic t_adapt;
    ok_req <= 1'b1;
    wait_smp(7990);
    axi_rd(8'h10);
    check(rd[0], 1'b1);
    wait_smp(20);
    axi_rd(8'h10);
    check(rd[2:0], 3'b000);
    ok_req <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    check(ec_coef_clear, 1'b1);
    rstn <= 1'b1;
    axi_rd(8'h10);
    check(rd[2:0], 3'b001);
  endtask
  // Far-end talk wins from idle; unity volume passes it within truncation while the near path is muted.
  task automatic t_duplex;
    logic [15:0] mag;
    amp_tx <= 16'h0800;
    amp_rx <= 16'h1880;
    wait_smp(16);
    mag = rx_out ^ {16{rx_out[15]}};
    check(tx_out, 16'h0000);
    check(mag[15:8], 8'h18);
    axi_rd(8'h10);
    check({rd[8], rd[6], rd[2:0]}, 5'b01101);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    total_checks = 0;
    rstn = 1'b0;
    ok_req = 1'b0;
    amp_tx = 16'h0000;
    amp_rx = 16'h0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    repeat (2) @(posedge clk_sys);
    check(ec_coef_clear, 1'b1);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_mute();
    t_idle_ret();
    t_adapt();
    t_duplex();
    results();
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule // tb_top
